// >>> verilog/clkmon_regs.svh
// Operation
// - Detector enable bit 0 switches detection on/off
// - Status bit 2 reports sample clock present
// - Status bit 1 reports clock is differential
// - Bit 3 set: single-ended clock powers converters down
// - Loss control set: lost clock powers converters down
// - Test register bit 1 enables constant test mode
// - Test register bit 0 gates top digital clock
// - Register 0x0F8 holds constant low byte, reset zero
// - Register 0x0F9 holds constant high byte, reset zero
`ifndef CLKMON_REGS_SVH
`define CLKMON_REGS_SVH

// ============================================================
// Register offsets
`define OFS_CLOCK_MONITOR     12'h08E
`define OFS_DIGITAL_TEST      12'h0F7
`define OFS_I_CONST_LOW       12'h0F8
`define OFS_I_CONST_HIGH      12'h0F9
`define OFS_EVENT_STATUS      12'h0F0
`define OFS_EVENT_MASK        12'h0F1

// ============================================================
// Field positions
`define BIT_DETECTOR_ENABLE   0
`define BIT_DIFFERENTIAL      1
`define BIT_CLOCK_PRESENT     2
`define BIT_PD_SINGLE_ENDED   3
`define BIT_PD_CLOCK_LOSS     4
`define BIT_DIG_CLOCK_GATE    0
`define BIT_CONST_TEST        1
`define EVT_CLOCK_LOST        0
`define EVT_SINGLE_ENDED      1
`define EVT_POWERDOWN         2

// ============================================================
// Reset values
`define RST_CLOCK_MONITOR     8'h00
`define RST_DIGITAL_TEST      8'h00
`define RST_I_CONST_BYTE      8'h00
`define RST_EVENT_MASK        8'h00

// ============================================================
// Timing
`define CLOCK_RATE_MHZ        100
`define ACTIVITY_WINDOW_NS    1000
`define ACTIVITY_WINDOW_CYC   ((`ACTIVITY_WINDOW_NS * `CLOCK_RATE_MHZ) / 1000)

`endif

// >>> verilog/clkmon_pkg.sv
`default_nettype none
package clkmon_pkg;
    typedef logic [11:0] reg_addr_t;
    typedef logic [7:0]  reg_byte_t;
    typedef logic [15:0] sample_t;

    typedef enum logic [1:0] {
        DET_OFF    = 2'b00,
        DET_SETTLE = 2'b01,
        DET_RUN    = 2'b10
    } detector_state_t;
endpackage
`default_nettype wire

// >>> verilog/sample_if.sv
`timescale 1ns/100ps
`default_nettype none
interface sample_if;
    import clkmon_pkg::*;
    sample_t data;
    logic    valid;
    modport source (output data, output valid);
    modport sink   (input  data, input  valid);
endinterface // sample_if
`default_nettype wire

// >>> verilog/activity_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module activity_monitor #(
    parameter int WINDOW = 100
) (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic enable,
    input  wire logic pin,
    output logic      active
);
    logic                     sync_first;
    logic                     sync_second;
    logic                     last_level;
    logic [$clog2(WINDOW):0]  quiet_count;

    // ============================================================
    // Synchroniser; only the second flop is looked at
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sync_first  <= 1'b0;
            sync_second <= 1'b0;
            last_level  <= 1'b0;
        end else begin
            sync_first  <= pin;
            sync_second <= sync_first;
            last_level  <= sync_second;
        end
    end

    // ============================================================
    // A leg is active while an edge was seen inside the window
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            quiet_count <= '0;
            active      <= 1'b0;
        end else if (!enable) begin
            quiet_count <= '0;
            active      <= 1'b0;
        end else if (sync_second != last_level) begin
            quiet_count <= '0;
            active      <= 1'b1;
        end else if (quiet_count >= ($clog2(WINDOW)+1)'(WINDOW - 1)) begin
            active      <= 1'b0;
        end else begin
            quiet_count <= quiet_count + 1'b1;
        end
    end
endmodule // activity_monitor
`default_nettype wire

// >>> verilog/constant_substitute.sv
`timescale 1ns/100ps
`default_nettype none
module constant_substitute
    import clkmon_pkg::*;
(
    input  wire logic    clock,
    input  wire logic    rst,
    input  wire logic    run,
    input  wire logic    use_constant,
    input  wire sample_t constant_value,
    sample_if.sink       upstream,
    sample_if.source     downstream
);
    // ============================================================
    // One register stage; a gated clock holds the data and drops valid
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            downstream.data  <= '0;
            downstream.valid <= 1'b0;
        end else if (!run) begin
            downstream.valid <= 1'b0;
        end else begin
            downstream.valid <= upstream.valid;
            if (use_constant) begin
                downstream.data <= constant_value;
            end else begin
                downstream.data <= upstream.data;
            end
        end
    end
endmodule // constant_substitute
`default_nettype wire

// >>> verilog/clock_monitor_block.sv
// The plain strobed port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "clkmon_regs.svh"
module clock_monitor_block #(
    parameter int WINDOW_CYCLES = `ACTIVITY_WINDOW_CYC
) (
    input  wire logic                   clock,
    input  wire logic                   rst,
    input  wire clkmon_pkg::reg_addr_t  reg_addr,
    input  wire clkmon_pkg::reg_byte_t  reg_wdata,
    input  wire logic                   reg_write,
    input  wire logic                   reg_read,
    output clkmon_pkg::reg_byte_t       reg_rdata,
    input  wire logic                   sample_clock_p,
    input  wire logic                   sample_clock_n,
    input  wire clkmon_pkg::sample_t    i_sample_in,
    input  wire logic                   i_sample_in_valid,
    output clkmon_pkg::sample_t         i_sample_out,
    output logic                        i_sample_out_valid,
    output logic                        converter_powerdown,
    output logic                        top_digital_clock_gate,
    output logic                        irq
);
    import clkmon_pkg::*;

    // ============================================================
    // Register storage
    reg_byte_t        clock_monitor_ctrl_status;
    reg_byte_t        digital_test_ctrl;
    reg_byte_t        i_test_constant_low;
    reg_byte_t        i_test_constant_high;
    reg_byte_t        event_status;
    reg_byte_t        event_mask;

    logic             detector_enable;
    logic             powerdown_on_single_ended;
    logic             powerdown_on_clock_loss;
    logic             constant_test_enable;
    sample_t          i_test_constant;

    // ============================================================
    // Detector state
    detector_state_t  det_state;
    detector_state_t  next_det_state;
    logic [$clog2(WINDOW_CYCLES):0] settle_count;
    logic             p_active;
    logic             n_active;
    logic             leg_enable;
    logic             clock_present_flag;
    logic             clock_differential_flag;
    logic             prev_present;
    logic             prev_differential;
    logic             prev_powerdown;
    logic             next_powerdown;
    reg_byte_t        event_set;
    reg_byte_t        read_value;
    logic             status_read;

    assign detector_enable           =
        clock_monitor_ctrl_status[`BIT_DETECTOR_ENABLE];
    assign powerdown_on_single_ended =
        clock_monitor_ctrl_status[`BIT_PD_SINGLE_ENDED];
    assign powerdown_on_clock_loss   =
        clock_monitor_ctrl_status[`BIT_PD_CLOCK_LOSS];
    assign constant_test_enable      =
        digital_test_ctrl[`BIT_CONST_TEST];
    assign i_test_constant = {i_test_constant_high, i_test_constant_low};

    // ============================================================
    // Pin legs of the sample clock
    // Monitors are held cleared while the detector is off
    assign leg_enable = detector_enable;

    activity_monitor #(
        .WINDOW (WINDOW_CYCLES)
    ) p_leg (
        .clock  (clock),
        .rst    (rst),
        .enable (leg_enable),
        .pin    (sample_clock_p),
        .active (p_active)
    );

    activity_monitor #(
        .WINDOW (WINDOW_CYCLES)
    ) n_leg (
        .clock  (clock),
        .rst    (rst),
        .enable (leg_enable),
        .pin    (sample_clock_n),
        .active (n_active)
    );

    // ============================================================
    // Detector sequencing
    // Settling for one window avoids a false loss report right
    // after enabling, before any edge could have been seen.
    always_comb begin
        next_det_state = det_state;
        case (det_state)
            DET_OFF: begin
                if (detector_enable) begin
                    next_det_state = DET_SETTLE;
                end
            end
            DET_SETTLE: begin
                if (!detector_enable) begin
                    next_det_state = DET_OFF;
                end else if (settle_count >=
                    ($clog2(WINDOW_CYCLES)+1)'(WINDOW_CYCLES - 1)) begin
                    next_det_state = DET_RUN;
                end
            end
            DET_RUN: begin
                if (!detector_enable) begin
                    next_det_state = DET_OFF;
                end
            end
            default: begin
                next_det_state = DET_OFF;
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            det_state <= DET_OFF;
        end else begin
            det_state <= next_det_state;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            settle_count <= '0;
        end else if (det_state != DET_SETTLE) begin
            settle_count <= '0;
        end else begin
            settle_count <= settle_count + 1'b1;
        end
    end

    // ============================================================
    // Status flags
    // A single-ended source leaves the complementary leg static,
    // so differential means both legs toggle.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            clock_present_flag      <= 1'b0;
            clock_differential_flag <= 1'b0;
        end else if (det_state != DET_RUN) begin
            clock_present_flag      <= 1'b0;
            clock_differential_flag <= 1'b0;
        end else begin
            clock_present_flag      <= p_active | n_active;
            clock_differential_flag <= p_active & n_active;
        end
    end

    // ============================================================
    // Automatic converter power-down
    always_comb begin
        next_powerdown = 1'b0;
        if (det_state == DET_RUN) begin
            if (powerdown_on_clock_loss && !clock_present_flag) begin
                next_powerdown = 1'b1;
            end
            if (powerdown_on_single_ended && clock_present_flag &&
                !clock_differential_flag) begin
                next_powerdown = 1'b1;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            converter_powerdown <= 1'b0;
        end else begin
            converter_powerdown <= next_powerdown;
        end
    end

    // ============================================================
    // Event detection
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            prev_present      <= 1'b0;
            prev_differential <= 1'b0;
            prev_powerdown    <= 1'b0;
        end else begin
            prev_present      <= clock_present_flag;
            prev_differential <= clock_differential_flag;
            prev_powerdown    <= converter_powerdown;
        end
    end

    // Loss is only reported while running, not when disabling
    always_comb begin
        event_set = '0;
        event_set[`EVT_CLOCK_LOST] = (det_state == DET_RUN) &&
            prev_present && !clock_present_flag;
        event_set[`EVT_SINGLE_ENDED] = (det_state == DET_RUN) &&
            clock_present_flag && prev_differential &&
            !clock_differential_flag;
        event_set[`EVT_POWERDOWN] = converter_powerdown && !prev_powerdown;
    end

    assign status_read = reg_read && (reg_addr == `OFS_EVENT_STATUS);

    // Set wins over the clear of a read in the same cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            event_status <= '0;
        end else if (status_read) begin
            event_status <= event_set;
        end else begin
            event_status <= event_status | event_set;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |((event_status | event_set) & event_mask &
                     ~(status_read ? event_status : 8'h00));
        end
    end

    // ============================================================
    // Register writes
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            clock_monitor_ctrl_status <= `RST_CLOCK_MONITOR;
        end else if (reg_write && reg_addr == `OFS_CLOCK_MONITOR) begin
            // Status positions are not stored; they read live
            clock_monitor_ctrl_status <= reg_wdata &
                ~((8'h01 << `BIT_CLOCK_PRESENT) |
                  (8'h01 << `BIT_DIFFERENTIAL));
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            digital_test_ctrl <= `RST_DIGITAL_TEST;
        end else if (reg_write && reg_addr == `OFS_DIGITAL_TEST) begin
            digital_test_ctrl <= reg_wdata;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            i_test_constant_low <= `RST_I_CONST_BYTE;
        end else if (reg_write && reg_addr == `OFS_I_CONST_LOW) begin
            i_test_constant_low <= reg_wdata;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            i_test_constant_high <= `RST_I_CONST_BYTE;
        end else if (reg_write && reg_addr == `OFS_I_CONST_HIGH) begin
            i_test_constant_high <= reg_wdata;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            event_mask <= `RST_EVENT_MASK;
        end else if (reg_write && reg_addr == `OFS_EVENT_MASK) begin
            event_mask <= reg_wdata;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            top_digital_clock_gate <= 1'b0;
        end else begin
            top_digital_clock_gate <=
                digital_test_ctrl[`BIT_DIG_CLOCK_GATE];
        end
    end

    // ============================================================
    // Register reads; unmapped addresses return zero
    always_comb begin
        read_value = 8'h00;
        case (reg_addr)
            `OFS_CLOCK_MONITOR: begin
                read_value = clock_monitor_ctrl_status;
                read_value[`BIT_CLOCK_PRESENT] = clock_present_flag;
                read_value[`BIT_DIFFERENTIAL] =
                    clock_differential_flag;
            end
            `OFS_DIGITAL_TEST: begin
                read_value = digital_test_ctrl;
            end
            `OFS_I_CONST_LOW: begin
                read_value = i_test_constant_low;
            end
            `OFS_I_CONST_HIGH: begin
                read_value = i_test_constant_high;
            end
            `OFS_EVENT_STATUS: begin
                read_value = event_status;
            end
            `OFS_EVENT_MASK: begin
                read_value = event_mask;
            end
            default: begin
                read_value = 8'h00;
            end
        endcase
    end

    // Read data stands for exactly one cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            reg_rdata <= read_value;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ============================================================
    // I-channel datapath
    sample_if upstream ();
    sample_if downstream ();

    assign upstream.data  = i_sample_in;
    assign upstream.valid = i_sample_in_valid;

    constant_substitute i_path (
        .clock          (clock),
        .rst            (rst),
        .run            (!digital_test_ctrl[`BIT_DIG_CLOCK_GATE]),
        .use_constant   (constant_test_enable),
        .constant_value (i_test_constant),
        .upstream       (upstream.sink),
        .downstream     (downstream.source)
    );

    assign i_sample_out       = downstream.data;
    assign i_sample_out_valid = downstream.valid;
endmodule // clock_monitor_block
`default_nettype wire

// >>> testbench/sample_clock_source.sv
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// Converter sample clock source
// Mode 0: stopped, 1: differential, 2: single-ended (complement leg idle)
module sample_clock_source (
    input  wire logic [1:0] mode,
    output logic            clk_p,
    output logic            clk_n
);
    initial clk_p = 1'b0;
    // A stopped clock stands still, which is what the detector must notice
    always #7 if (mode != 2'd0) clk_p = ~clk_p;
    // Single-ended drive leaves the complement leg parked low
    assign clk_n = (mode == 2'd1) ? ~clk_p : 1'b0;
endmodule // sample_clock_source
`default_nettype wire

// >>> testbench/clock_monitor_block_monitor.sv
`timescale 1ns/100ps
`default_nettype none
`include "clkmon_regs.svh"
// ============================================================
// Port-level checker
module clock_monitor_block_checker
    import clkmon_pkg::*;
#(
    parameter int WINDOW_CYCLES = 8
) (
    input wire logic                  clock,
    input wire logic                  rst,
    input wire clkmon_pkg::reg_addr_t reg_addr,
    input wire clkmon_pkg::reg_byte_t reg_wdata,
    input wire logic                  reg_write,
    input wire logic                  reg_read,
    input wire clkmon_pkg::reg_byte_t reg_rdata,
    input wire logic                  sample_clock_p,
    input wire logic                  sample_clock_n,
    input wire clkmon_pkg::sample_t   i_sample_in,
    input wire logic                  i_sample_in_valid,
    input wire clkmon_pkg::sample_t   i_sample_out,
    input wire logic                  i_sample_out_valid,
    input wire logic                  converter_powerdown,
    input wire logic                  top_digital_clock_gate,
    input wire logic                  irq
);
    reg_byte_t ctrl;
    reg_byte_t test;
    reg_byte_t mask;
    sample_t   konst;

    // Shadows rebuilt from bus writes only, never from design state
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl  <= 8'h00;
            test  <= 8'h00;
            mask  <= 8'h00;
            konst <= 16'h0000;
        end else if (reg_write) begin
            case (reg_addr)
                `OFS_CLOCK_MONITOR: ctrl <= reg_wdata;
                `OFS_DIGITAL_TEST:  test <= reg_wdata;
                `OFS_EVENT_MASK:    mask <= reg_wdata;
                `OFS_I_CONST_LOW:   konst[7:0] <= reg_wdata;
                `OFS_I_CONST_HIGH:  konst[15:8] <= reg_wdata;
                default: ;
            endcase
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence wr_test_s;
        reg_write && reg_addr == `OFS_DIGITAL_TEST;
    endsequence
    sequence rd_const_s;
        reg_read && reg_addr inside {`OFS_I_CONST_LOW, `OFS_I_CONST_HIGH};
    endsequence

    rdata_idle_a: assert property (!reg_read |=> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    unmapped_read_a: assert property (reg_read && !(reg_addr inside
        {`OFS_CLOCK_MONITOR, `OFS_DIGITAL_TEST, `OFS_I_CONST_LOW,
         `OFS_I_CONST_HIGH, `OFS_EVENT_STATUS, `OFS_EVENT_MASK})
        |=> reg_rdata == 8'h00)
        else $error("unmapped read returned data");
    const_read_a: assert property (rd_const_s |=> reg_rdata ==
        (($past(reg_addr) == `OFS_I_CONST_LOW) ? konst[7:0] : konst[15:8]))
        else $error("constant byte readback wrong");
    gate_follow_a: assert property (wr_test_s |=> ##1
        top_digital_clock_gate == test[0])
        else $error("clock gate does not follow test bit");
    gate_blocks_a: assert property (top_digital_clock_gate && test[0]
        |=> !i_sample_out_valid)
        else $error("sample passed while clock gated");
    sample_path_a: assert property (i_sample_in_valid && !test[0]
        |=> i_sample_out_valid && i_sample_out ==
        ((($past(test) & 8'h02) != 8'h00) ? $past(konst) : $past(i_sample_in)))
        else $error("sample output wrong");
    pd_cause_a: assert property ($rose(converter_powerdown)
        |-> ctrl[0] && (ctrl[3] || ctrl[4]))
        else $error("power-down without enabled cause");
    pd_off_a: assert property (!ctrl[0] [*4] |-> !converter_powerdown)
        else $error("power-down with detector off");
    irq_masked_a: assert property (mask == 8'h00 [*2] |-> !irq)
        else $error("interrupt with all events masked");
endmodule // clock_monitor_block_checker

bind clock_monitor_block clock_monitor_block_checker #(
    .WINDOW_CYCLES(WINDOW_CYCLES)
) u_checker (
    .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .sample_clock_p(sample_clock_p), .sample_clock_n(sample_clock_n),
    .i_sample_in(i_sample_in), .i_sample_in_valid(i_sample_in_valid),
    .i_sample_out(i_sample_out), .i_sample_out_valid(i_sample_out_valid),
    .converter_powerdown(converter_powerdown),
    .top_digital_clock_gate(top_digital_clock_gate), .irq(irq)
);
`default_nettype wire

// >>> testbench/clock_monitor_block_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// Testbench top
module clock_monitor_block_tb_top;
    import clkmon_pkg::*;
    localparam int WIN = 8;
    typedef struct {reg_addr_t a; reg_byte_t w; reg_byte_t r;} row_t;
    logic      clock, rst, reg_write, reg_read, i_sample_in_valid;
    logic      i_sample_out_valid, converter_powerdown;
    logic      top_digital_clock_gate, irq, clk_p, clk_n;
    logic [1:0] clk_mode;
    reg_addr_t reg_addr;
    reg_byte_t reg_wdata, reg_rdata, d;
    sample_t   i_sample_in, i_sample_out;
    int        error_cnt, tests_run;
    reg_addr_t rst_addr[6] = '{12'h08E, 12'h0F7, 12'h0F8, 12'h0F9,
                               12'h0F0, 12'h0F1};
    // Status bits stay zero with the detector off; Q constant is unmapped
    row_t rows[9] = '{'{12'h08E, 8'hE0, 8'hE0}, '{12'h08E, 8'h06, 8'h00},
                      '{12'h0F7, 8'hFC, 8'hFC}, '{12'h0F7, 8'h00, 8'h00},
                      '{12'h0F8, 8'hA5, 8'hA5}, '{12'h0F9, 8'h5A, 8'h5A},
                      '{12'h0F1, 8'h00, 8'h00}, '{12'h123, 8'hFF, 8'h00},
                      '{12'h0FA, 8'h11, 8'h00}};

    clock_monitor_block #(.WINDOW_CYCLES(WIN)) dut (
        .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .sample_clock_p(clk_p), .sample_clock_n(clk_n),
        .i_sample_in(i_sample_in), .i_sample_in_valid(i_sample_in_valid),
        .i_sample_out(i_sample_out), .i_sample_out_valid(i_sample_out_valid),
        .converter_powerdown(converter_powerdown),
        .top_digital_clock_gate(top_digital_clock_gate), .irq(irq));
    sample_clock_source u_clk_src (.mode(clk_mode), .clk_p(clk_p),
                                   .clk_n(clk_n));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic give_verdict();
        if (error_cnt == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic fail(input string m);
        error_cnt++;
        $display("FAIL %0t %s", $time, m);
    endtask
    task automatic chk8(input reg_byte_t g, input reg_byte_t e, string m);
        tests_run++;
        if (g !== e) fail(m);
    endtask
    task automatic chk1(input logic g, input logic e, input string m);
        tests_run++;
        if (g !== e) fail(m);
    endtask
    task automatic chk16(input sample_t g, input sample_t e, string m);
        tests_run++;
        if (g !== e) fail(m);
    endtask
    task automatic wr(input reg_addr_t a, input reg_byte_t v);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input reg_addr_t a, output reg_byte_t v);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic rd_chk(input reg_addr_t a, input reg_byte_t e);
        reg_byte_t v;
        rd(a, v);
        chk8(v, e, "register read");
    endtask
    task automatic samp(input sample_t v, input sample_t e, input logic ev);
        @(posedge clock);
        i_sample_in <= v;
        i_sample_in_valid <= 1'b1;
        @(posedge clock);
        i_sample_in_valid <= 1'b0;
        #1 chk1(i_sample_out_valid, ev, "sample valid");
        if (ev) chk16(i_sample_out, e, "sample data");
    endtask
    // Which 0: power-down, 1: interrupt
    task automatic wait_for(input int which, input logic v, input int lim);
        int n;
        n = 0;
        while ((which ? irq : converter_powerdown) !== v && n < lim) begin
            @(posedge clock);
            #1 n++;
        end
        if (n >= lim) begin
            fail("wait timed out");
            give_verdict();
        end
    endtask

    initial begin
        rst = 1'b1;
        reg_addr = 12'h000;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
        i_sample_in = 16'h0000;
        i_sample_in_valid = 1'b0;
        clk_mode = 2'd1;
        error_cnt = 0;
        tests_run = 0;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        foreach (rst_addr[i]) rd_chk(rst_addr[i], 8'h00);
        chk1(converter_powerdown, 1'b0, "power-down at reset");
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rd_chk(rows[i].a, rows[i].r);
        end
        // Constant substitution, pass-through and clock gating
        wr(12'h0F8, 8'h34);
        wr(12'h0F9, 8'h12);
        wr(12'h0F7, 8'h02);
        samp(16'hBEEF, 16'h1234, 1'b1);
        samp(16'h0001, 16'h1234, 1'b1);
        wr(12'h0F7, 8'h00);
        samp(16'hBEEF, 16'hBEEF, 1'b1);
        wr(12'h0F7, 8'h01);
        repeat (2) @(posedge clock);
        #1 chk1(top_digital_clock_gate, 1'b1, "clock gate set");
        samp(16'hBEEF, 16'h0000, 1'b0);
        wr(12'h0F7, 8'h00);
        // Detector: settle on a differential clock, only clock loss unmasked
        wr(12'h0F1, 8'h01);
        wr(12'h08E, 8'h09);
        repeat (WIN + 10) @(posedge clock);
        rd_chk(12'h08E, 8'h0F);
        chk1(converter_powerdown, 1'b0, "no power-down");
        clk_mode <= 2'd2;
        wait_for(0, 1'b1, WIN + 20);
        rd_chk(12'h08E, 8'h0D);
        chk1(irq, 1'b0, "masked events raise no interrupt");
        rd_chk(12'h0F0, 8'h06);
        rd_chk(12'h0F0, 8'h00);
        // Loss control only: single-ended is not powered down, a stopped clock powers down and interrupts
        wr(12'h08E, 8'h11);
        wait_for(0, 1'b0, 20);
        clk_mode <= 2'd0;
        wait_for(0, 1'b1, WIN + 20);
        repeat (3) @(posedge clock);
        #1 chk1(irq, 1'b1, "clock loss interrupt");
        rd_chk(12'h08E, 8'h11);
        rd_chk(12'h0F0, 8'h05);
        wait_for(1, 1'b0, 5);
        wr(12'h08E, 8'h10);
        wait_for(0, 1'b0, 10);
        rd_chk(12'h08E, 8'h10);
        // Second reset in mid-run restores the defaults
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        rd_chk(12'h0F8, 8'h00);
        rd_chk(12'h0F9, 8'h00);
        rd_chk(12'h0F7, 8'h00);
        give_verdict();
    end
endmodule // clock_monitor_block_tb_top
`default_nettype wire
